// ==== rtl/mcsp_map.svh ====
// Address map, field positions, widths and reset values of the motor serial port.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data, one word per register.
//
// How it works
// - Sample data and strobe at serial clock rise
// - Strobe low frames word; bits taken only then
// - Bits shift in serially, first bit ends highest
// - Reset clears all 29 bits, predecessor compatible
// - Reset pin low: sleep, clear all config
// - Brake pin low turns on all sinks
// - Serial brake bit also applies braking
// - Two-bit selector routes one of four diagnostics
// - Speed reference counter runs from oscillator input
// - External pulse train feeds speed loop
// - Indicator toggles at each back-EMF zero crossing
`ifndef MCSP_MAP_SVH
`define MCSP_MAP_SVH

// Serial configuration word
`define MCSP_CFG_W        29
`define MCSP_CFG_RESET    29'h0000000
`define MCSP_CFG_BRAKE    2
`define MCSP_CFG_DIAG_LO  5
`define MCSP_CFG_DIAG_HI  6
`define MCSP_CFG_EXT_SPEED_PULSE 7
`define MCSP_CFG_SLEEP    8
`define MCSP_BITCNT_W     5
`define MCSP_BITCNT_ZERO  5'h00
`define MCSP_BITCNT_MAX   5'h1D

// Diagnostic selector codes
`define MCSP_DIAG_THERM   2'h0
`define MCSP_DIAG_ZC      2'h1
`define MCSP_DIAG_SPEED   2'h2
`define MCSP_DIAG_SYNC    2'h3

// Register byte offsets
`define MCSP_ADDR_W       8
`define MCSP_REG_CONFIG   8'h00
`define MCSP_REG_STATUS   8'h04
`define MCSP_REG_MASK     8'h08
`define MCSP_REG_PERIOD   8'h0C
`define MCSP_REG_REFCNT   8'h10

// Status and mask bit positions
`define MCSP_EVT_W        5
`define MCSP_EVT_WORD     0
`define MCSP_EVT_ZC       1
`define MCSP_EVT_SPEED    2
`define MCSP_EVT_BRAKE    3
`define MCSP_EVT_RSTPIN   4
`define MCSP_EVT_RESET    5'h00

// Speed reference counter
`define MCSP_REF_W        16
`define MCSP_REF_RESET    16'h0000
`define MCSP_REF_ONE      16'h0001

// Pin synchroniser width
`define MCSP_PIN_W        8
// Idle level of each pin lane: brake, reset pin and strobe rest high
`define MCSP_PIN_IDLE     8'h1C

`endif

// ==== rtl/mcsp_pkg.sv ====
// Types shared by the motor serial port design.
// Assumes mcsp_map.svh supplies the widths.
`include "mcsp_map.svh"

package mcsp_pkg;

  // Pins from outside the clock domain, all synchronised together
  typedef struct packed {
    logic bemf_above;  // Back-EMF comparator against centertap
    logic sector;      // External speed pulse train
    logic osc;         // Speed reference oscillator
    logic brake_n;     // Brake request, active low
    logic rst_pin_n;   // Reset pin, active low
    logic ser_strobe_n; // Word strobe, active low
    logic ser_data;    // Serial data in
    logic ser_clk;     // Serial port clock
  } mcsp_pins_t;

  // Serial word framing states
  typedef enum logic [0:0] {
    MCSP_IDLE,
    MCSP_SHIFT
  } mcsp_frame_t;

endpackage

// ==== rtl/mcsp_sync.sv ====
// Two-flop synchroniser with edge detection, one lane per pin.
// Assumes inputs are asynchronous to clk; the first flop feeds only the second.
module mcsp_sync #(
  parameter int           W    = 8,
  parameter logic [W-1:0] IDLE = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Asynchronous pins
  input  wire logic [W-1:0] async_in,
  // Synchronised level and edge pulses
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  for (genvar i = 0; i < W; i++)
  begin : g_lane
    logic meta_q;   // First stage, read only by the second
    logic sync_q;   // Second stage, safe level
    logic prev_q;   // Delayed copy for edge finding

    // Three-stage chain; reset to the pin's idle level so no edge is seen on release
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        meta_q <= IDLE[i];
        sync_q <= IDLE[i];
        prev_q <= IDLE[i];
      end
      else
      begin
        meta_q <= async_in[i];
        sync_q <= meta_q;
        prev_q <= sync_q;
      end
    end

    assign level[i] = sync_q;
    assign rise[i]  = sync_q & ~prev_q;
    assign fall[i]  = ~sync_q & prev_q;
  end

endmodule

// ==== rtl/mcsp_top.sv ====
// Serial control port of a three-phase motor controller, with brake, diagnostic
// selector, speed reference counter and an Avalon-MM register window.
// Assumes all pins are asynchronous to clk (250 MHz) and the serial clock is far
// slower than clk, so each of its edges is seen after synchronisation.
`include "mcsp_map.svh"

module mcsp_top (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Device pins
  input  wire mcsp_pkg::mcsp_pins_t      pins,
  // Internal status sources on clk
  input  wire logic                      thermal_flag,
  input  wire logic                      speed_pulse_internal,
  input  wire logic                      sync_flag,
  // Avalon-MM slave
  input  wire logic [`MCSP_ADDR_W-1:0]   avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // Motor side outputs
  output logic                           data_out,
  output logic      [2:0]                sink_on,
  output logic                           sleep,
  output logic                           zero_cross_indicator,
  output logic                           speed_pulse,
  // Interrupt
  output logic                           irq
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  mcsp_pkg::mcsp_pins_t pin_lvl;   // Synchronised levels
  mcsp_pkg::mcsp_pins_t pin_rise;  // One-cycle rise pulses
  mcsp_pkg::mcsp_pins_t pin_fall;  // One-cycle fall pulses

  mcsp_sync #(
    .W    (`MCSP_PIN_W),
    .IDLE (`MCSP_PIN_IDLE)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (pins),
    .level    (pin_lvl),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  mcsp_pkg::mcsp_frame_t          frame_q, frame_d;   // Word framing state
  logic [`MCSP_CFG_W-1:0]         shift_q, shift_d;   // Incoming word
  logic [`MCSP_BITCNT_W-1:0]      bits_q, bits_d;     // Bits in current word
  logic [`MCSP_CFG_W-1:0]         cfg_q, cfg_d;       // Active configuration
  logic                           zc_q;               // Zero-crossing indicator
  logic                           spd_q;              // Selected speed pulse
  logic [`MCSP_REF_W-1:0]         ref_q;              // Oscillator edge count
  logic [`MCSP_REF_W-1:0]         period_q;           // Count between speed pulses
  logic [`MCSP_EVT_W-1:0]         status_q, status_d; // Sticky events
  logic [`MCSP_EVT_W-1:0]         mask_q;             // Interrupt mask
  logic                           data_out_q;
  logic [2:0]                     sink_q;
  logic                           sleep_q;
  logic                           irq_q;
  logic                           wait_q;             // Waitrequest, high by default
  logic [31:0]                    rdata_q;

  // ---------------------------------------------------------------------------
  // Serial word capture
  // ---------------------------------------------------------------------------
  // sample on clock rise
  wire  ser_edge   = pin_rise.ser_clk;
  wire  ser_bit    = pin_lvl.ser_data;
  wire  strobe_low = ~pin_lvl.ser_strobe_n;
  wire  take_bit   = ser_edge & strobe_low;
  wire  word_end   = pin_rise.ser_strobe_n & (frame_q == mcsp_pkg::MCSP_SHIFT);
  wire  word_load  = word_end & (bits_q != `MCSP_BITCNT_ZERO);
  wire  pin_reset  = ~pin_lvl.rst_pin_n;
  wire  bits_full  = (bits_q == `MCSP_BITCNT_MAX);

  // Framing machine: a word opens on the first clock rise that sees strobe low
  // and closes when the strobe pin returns high; the host never lets the two
  // edges meet, so no bit is ever taken together with the closing edge.
  always_comb
  begin
    frame_d = frame_q;
    shift_d = shift_q;
    bits_d  = bits_q;
    case (frame_q)
      mcsp_pkg::MCSP_IDLE:
      begin
        // A fresh word starts from zero so short words leave top bits clear
        if (take_bit)
        begin
          frame_d = mcsp_pkg::MCSP_SHIFT;
          shift_d = {{(`MCSP_CFG_W-1){1'b0}}, ser_bit};
          bits_d  = `MCSP_BITCNT_ZERO + 5'h01;
        end
      end
      mcsp_pkg::MCSP_SHIFT:
      begin
        if (word_end)
        begin
          frame_d = mcsp_pkg::MCSP_IDLE;
        end
        else if (take_bit)
        begin
          shift_d = {shift_q[`MCSP_CFG_W-2:0], ser_bit};
          // Counter saturates; extra bits just push old ones out
          if (!bits_full)
          begin
            bits_d = bits_q + 5'h01;
          end
        end
      end
      default:
      begin
        frame_d = mcsp_pkg::MCSP_IDLE;
      end
    endcase
    // Reset pin abandons any word in flight
    if (pin_reset)
    begin
      frame_d = mcsp_pkg::MCSP_IDLE;
      shift_d = `MCSP_CFG_RESET;
      bits_d  = `MCSP_BITCNT_ZERO;
    end
  end

  // Configuration: only a closed word of at least one bit is ever applied.
  // top bits reset zero
  assign cfg_d = pin_reset ? `MCSP_CFG_RESET :
                 word_load ? shift_q : cfg_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      frame_q <= mcsp_pkg::MCSP_IDLE;
      shift_q <= `MCSP_CFG_RESET;
      bits_q  <= `MCSP_BITCNT_ZERO;
      cfg_q   <= `MCSP_CFG_RESET;
    end
    else
    begin
      frame_q <= frame_d;
      shift_q <= shift_d;
      bits_q  <= bits_d;
      cfg_q   <= cfg_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Motor-side controls
  // ---------------------------------------------------------------------------
  // brake pin low
  wire       brake_pin = ~pin_lvl.brake_n;
  wire       brake_req = brake_pin | cfg_q[`MCSP_CFG_BRAKE];
  // Sleep comes from the reset pin or the serial sleep bit
  wire       sleep_d   = pin_reset | cfg_q[`MCSP_CFG_SLEEP];
  wire [1:0] diag_sel  = cfg_q[`MCSP_CFG_DIAG_HI:`MCSP_CFG_DIAG_LO];
  wire       spd_src   = cfg_q[`MCSP_CFG_EXT_SPEED_PULSE] ? pin_lvl.sector : speed_pulse_internal;
  wire       spd_rise  = spd_src & ~spd_q;
  wire       zc_event  = pin_rise.bemf_above | pin_fall.bemf_above;
  wire       ref_tick  = pin_rise.osc;

  wire       diag_d    = (diag_sel == `MCSP_DIAG_THERM) ? thermal_flag :
                         (diag_sel == `MCSP_DIAG_ZC)    ? zc_q :
                         (diag_sel == `MCSP_DIAG_SPEED) ? spd_q : sync_flag;

  // Brake, sleep and indicator flops; all motor-side outputs come straight from here
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sink_q     <= 3'h0;
      sleep_q    <= 1'b0;
      zc_q       <= 1'b0;
      spd_q      <= 1'b0;
      data_out_q <= 1'b0;
    end
    else
    begin
      sink_q     <= {3{brake_req}};
      sleep_q    <= sleep_d;
      zc_q       <= zc_q ^ zc_event;
      spd_q      <= spd_src;
      data_out_q <= diag_d;
    end
  end

  // Speed reference counter: free counts of oscillator edges, restarted on each
  // speed pulse with the old count kept as the measured period. It wraps rather
  // than saturates, so a stalled motor shows a meaningless period.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ref_q    <= `MCSP_REF_RESET;
      period_q <= `MCSP_REF_RESET;
    end
    else if (spd_rise)
    begin
      period_q <= ref_q;
      ref_q    <= ref_tick ? `MCSP_REF_ONE : `MCSP_REF_RESET;
    end
    else if (ref_tick)
    begin
      ref_q    <= ref_q + `MCSP_REF_ONE;
    end
  end

  // ---------------------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------------------
  // One wait state: the first cycle of a request prepares read data and drops
  // waitrequest; the next edge is the only one at which the access takes effect.
  wire req        = avs_read | avs_write;
  wire acc        = req & ~wait_q;
  wire wr_acc     = acc & avs_write;
  wire rd_acc     = acc & avs_read;
  wire sel_config = (avs_address == `MCSP_REG_CONFIG);
  wire sel_status = (avs_address == `MCSP_REG_STATUS);
  wire sel_mask   = (avs_address == `MCSP_REG_MASK);
  wire sel_period = (avs_address == `MCSP_REG_PERIOD);
  wire sel_refcnt = (avs_address == `MCSP_REG_REFCNT);

  // Read mux; unmapped addresses read as zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_config)
    begin
      rd_mux = {{(32-`MCSP_CFG_W){1'b0}}, cfg_q};
    end
    else if (sel_status)
    begin
      rd_mux = {{(32-`MCSP_EVT_W){1'b0}}, status_q};
    end
    else if (sel_mask)
    begin
      rd_mux = {{(32-`MCSP_EVT_W){1'b0}}, mask_q};
    end
    else if (sel_period)
    begin
      rd_mux = {{(32-`MCSP_REF_W){1'b0}}, period_q};
    end
    else if (sel_refcnt)
    begin
      rd_mux = {{(32-`MCSP_REF_W){1'b0}}, ref_q};
    end
  end

  // Bus handshake flops
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else if (req && wait_q)
    begin
      wait_q  <= 1'b0;
      rdata_q <= rd_mux;
    end
    else
    begin
      wait_q  <= 1'b1;
    end
  end

  // Mask: only the low byte holds bits, so only its byte lane is honoured
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mask_q <= `MCSP_EVT_RESET;
    end
    else if (wr_acc && sel_mask && avs_byteenable[0])
    begin
      mask_q <= avs_writedata[`MCSP_EVT_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Events and interrupt
  // ---------------------------------------------------------------------------
  logic [`MCSP_EVT_W-1:0] evt;     // One-cycle event pulses
  logic [`MCSP_EVT_W-1:0] clr;     // Read-to-clear of the status register

  always_comb
  begin
    evt                  = `MCSP_EVT_RESET;
    evt[`MCSP_EVT_WORD]  = word_load;
    evt[`MCSP_EVT_ZC]    = zc_event;
    evt[`MCSP_EVT_SPEED] = spd_rise;
    evt[`MCSP_EVT_BRAKE] = brake_req & ~sink_q[0];
    evt[`MCSP_EVT_RSTPIN] = pin_fall.rst_pin_n;
    // Clear only what the read returned; a bit set after the data was latched stays
    clr                  = (rd_acc && sel_status) ? rdata_q[`MCSP_EVT_W-1:0] : `MCSP_EVT_RESET;
    // An event in the clearing cycle survives, since set wins over clear
    status_d             = (status_q & ~clr) | evt;
  end

  // Sticky status and level interrupt
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_q <= `MCSP_EVT_RESET;
      irq_q    <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_q    <= |(status_d & mask_q);
    end
  end

  // ---------------------------------------------------------------------------
  // Output drive
  // ---------------------------------------------------------------------------
  assign avs_readdata         = rdata_q;
  assign avs_waitrequest      = wait_q;
  assign data_out             = data_out_q;
  assign sink_on              = sink_q;
  assign sleep                = sleep_q;
  assign zero_cross_indicator = zc_q;
  assign speed_pulse          = spd_q;
  assign irq                  = irq_q;

endmodule

// ==== sim/mcsp_top_asserts.sv ====
// Checker for the motor serial port top, watching its ports only.
// Assumes pins are held steady for several clk cycles between changes.
`include "mcsp_map.svh"

module mcsp_top_asserts (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    sys_rst,
  // Inputs
  input wire mcsp_pkg::mcsp_pins_t    pins,
  input wire logic                    thermal_flag,
  input wire logic [`MCSP_ADDR_W-1:0] avs_address,
  input wire logic                    avs_waitrequest,
  input wire logic [31:0]             avs_readdata,
  // Motor side
  input wire logic                    data_out,
  input wire logic [2:0]              sink_on,
  input wire logic                    sleep,
  input wire logic                    zero_cross_indicator
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_BRAKE_PIN: assert property (!pins.brake_n [*8] |-> sink_on == 3'h7)
    else $error("sinks not on while brake pin low");
  // Sinks switch as one group, never partly
  AST_SINK_ALL: assert property (sink_on == 3'h0 || sink_on == 3'h7)
    else $error("sink drivers not switched together");
  // Cleared config leaves no serial brake request
  AST_SINK_OFF: assert property ((pins.brake_n && !pins.rst_pin_n) [*8] |-> sink_on == 3'h0)
    else $error("braking without any request");
  AST_RST_SLEEP: assert property (!pins.rst_pin_n [*8] |-> sleep)
    else $error("no sleep while reset pin low");
  AST_CFG_CLEAR: assert property ((!pins.rst_pin_n) [*8] ##0
    (!avs_waitrequest && avs_address == `MCSP_REG_CONFIG) |-> avs_readdata == 32'h0)
    else $error("config not cleared by reset pin");
  // Cleared selector picks the thermal flag
  AST_DIAG_THERM: assert property (!pins.rst_pin_n [*8] |-> data_out == $past(thermal_flag))
    else $error("diagnostic output not thermal flag");
  AST_ZC_FOLLOW: assert property ($changed(pins.bemf_above) |->
    ##[2:6] $changed(zero_cross_indicator))
    else $error("no indicator toggle after crossing");
  // Latency window covers two or three sync flops and one register
  AST_ZC_CAUSE: assert property ($changed(zero_cross_indicator) |->
    $past(pins.bemf_above, 3) != $past(pins.bemf_above, 6))
    else $error("indicator toggled without crossing");

  cover property (sink_on == 3'h7);
  cover property ($changed(zero_cross_indicator));
  cover property (!avs_waitrequest && avs_address == `MCSP_REG_CONFIG);
endmodule

// ==== sim/mcsp_host_model.sv ====
// Host model driving the write-only three-wire serial port.
// Assumes clk at 4 ns; the 80 ns serial clock is counted from it.
module mcsp_host_model (
  // System clock
  input wire logic clk,
  // Serial lines
  output logic     ser_clk,
  output logic     ser_data,
  output logic     ser_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: clock still and low, strobe high
  initial
  begin
    ser_clk      = 1'b0;
    ser_data     = 1'b0;
    ser_strobe_n = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Shift n bits of w; frame low clocks them with strobe high on purpose
  task automatic send(input logic [31:0] w, input int n, input logic frame);
    wt(1);
    ser_strobe_n <= ~frame;
    wt(25);
    for (int i = n - 1; i >= 0; i--)
    begin
      ser_data <= w[i];
      wt(10);
      ser_clk <= 1'b1;
      wt(10);
      ser_clk <= 1'b0;
    end
    wt(13);
    ser_strobe_n <= 1'b1;
    // Released line must not keep its last value
    ser_data <= ~ser_data;
    // Strobe high gap before any next word
    wt(125);
  endtask
endmodule

// ==== sim/mcsp_top_test.sv ====
// Self-checking bench of the motor serial port top.
// Assumes the host model drives the serial lines; the bench drives the rest.
`include "mcsp_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) \
  begin miscompares++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module mcsp_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus and observed signals
  logic                 clk, sys_rst, bemf, sector, osc, brake_n, rst_n;
  logic                 thermal_flag, speed_pulse_internal, sync_flag, avs_read, avs_write;
  logic [7:0]           avs_address;
  logic [31:0]          avs_writedata, avs_readdata, rd;
  logic [3:0]           avs_byteenable;
  logic                 avs_waitrequest, data_out, sleep, zci, speed_pulse, irq;
  logic [2:0]           sink_on;
  wire logic            sclk, sdat, sstb_n;
  mcsp_pkg::mcsp_pins_t pins;
  int                   miscompares, cmp_count;

  assign pins = {bemf, sector, osc, brake_n, rst_n, sstb_n, sdat, sclk};
  always #2 clk = ~clk;

  mcsp_host_model host (.clk(clk), .ser_clk(sclk), .ser_data(sdat), .ser_strobe_n(sstb_n));
  mcsp_top uut (.clk(clk), .sys_rst(sys_rst), .pins(pins), .thermal_flag(thermal_flag),
    .speed_pulse_internal(speed_pulse_internal), .sync_flag(sync_flag), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .data_out(data_out), .sink_on(sink_on),
    .sleep(sleep), .zero_cross_indicator(zci), .speed_pulse(speed_pulse), .irq(irq));

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // Timeout counts as a failure
    if (n == 50)
    begin
      miscompares++;
      end_of_test();
    end
  endtask

  // Reset values, mask access, unmapped place
  task automatic t_regs;
    bus(0, `MCSP_REG_CONFIG, 0);
    `CHK(rd, 32'h0)
    bus(1, 8'h14, 32'hFFFFFFFF);
    bus(0, 8'h14, 0);
    `CHK(rd, 32'h0)
    bus(1, `MCSP_REG_MASK, 32'h1F);
    bus(0, `MCSP_REG_MASK, 0);
    `CHK(rd, 32'h1F)
    bus(1, `MCSP_REG_MASK, 0);
    bus(0, `MCSP_REG_STATUS, 0);
    `CHK(rd, 32'h0)
  endtask

  // Full and short words load; bits clocked with strobe high are ignored
  task automatic t_word;
    host.send(32'h12345100, 29, 1);
    wt(8);
    bus(0, `MCSP_REG_CONFIG, 0);
    `CHK(rd, 32'h12345100)
    `CHK(sleep, 1'b1)
    bus(0, `MCSP_REG_STATUS, 0);
    `CHK(rd[0], 1'b1)
    host.send(32'h00000003, 29, 0);
    bus(0, `MCSP_REG_CONFIG, 0);
    `CHK(rd, 32'h12345100)
    host.send(32'h5, 3, 1);
    bus(0, `MCSP_REG_CONFIG, 0);
    `CHK(rd, 32'h5)
    `CHK(sleep, 1'b0)
  endtask

  // Every selector code, then the external speed pulse source
  task automatic t_diag;
    logic ex;
    for (int c = 0; c < 4; c++)
    begin
      host.send(c << 5, 29, 1);
      for (int v = 0; v < 2; v++)
      begin
        @(posedge clk);
        thermal_flag  <= v[0];
        speed_pulse_internal <= v[0];
        sync_flag     <= v[0];
        wt(8);
        ex = (c == 1) ? 1'b0 : v[0];
        `CHK(data_out, ex)
        `CHK(speed_pulse, v[0])
      end
    end
    host.send(32'h80, 29, 1);
    for (int v = 1; v >= 0; v--)
    begin
      @(posedge clk);
      sector <= v[0];
      wt(8);
      `CHK(speed_pulse, v[0])
    end
  endtask

  // Brake by pin with interrupt, then by serial bit while masked
  task automatic t_brake;
    bus(1, `MCSP_REG_MASK, 32'h08);
    bus(0, `MCSP_REG_STATUS, 0);
    @(posedge clk);
    brake_n <= 1'b0;
    wt(8);
    `CHK(sink_on, 3'h7)
    `CHK(irq, 1'b1)
    @(posedge clk);
    brake_n <= 1'b1;
    wt(8);
    `CHK(sink_on, 3'h0)
    bus(0, `MCSP_REG_STATUS, 0);
    `CHK(rd[3], 1'b1)
    wt(3);
    `CHK(irq, 1'b0)
    bus(1, `MCSP_REG_MASK, 0);
    host.send(32'h4, 29, 1);
    wt(8);
    `CHK(sink_on, 3'h7)
    `CHK(irq, 1'b0)
  endtask

  // Reset pin sleeps and clears the serial brake bit
  task automatic t_rstpin;
    @(posedge clk);
    rst_n <= 1'b0;
    wt(8);
    `CHK(sleep, 1'b1)
    `CHK(sink_on, 3'h0)
    bus(0, `MCSP_REG_CONFIG, 0);
    `CHK(rd, 32'h0)
    @(posedge clk);
    rst_n <= 1'b1;
    wt(8);
    `CHK(sleep, 1'b0)
    bus(0, `MCSP_REG_STATUS, 0);
    `CHK(rd[4], 1'b1)
  endtask

  // Each comparator edge toggles the indicator once
  task automatic t_zc;
    logic z;
    z = 1'b0;
    repeat (3)
    begin
      @(posedge clk);
      bemf <= ~bemf;
      wt(10);
      z = ~z;
      `CHK(zci, z)
    end
    bus(0, `MCSP_REG_STATUS, 0);
    `CHK(rd[1], 1'b1)
  endtask

  // Ten oscillator rises advance the reference count by ten
  task automatic t_osc;
    logic [15:0] r0;
    bus(0, `MCSP_REG_REFCNT, 0);
    r0 = rd[15:0];
    repeat (10)
    begin
      @(posedge clk);
      osc <= 1'b1;
      wt(4);
      osc <= 1'b0;
      wt(3);
    end
    wt(6);
    bus(0, `MCSP_REG_REFCNT, 0);
    `CHK(rd[15:0] - r0, 16'h000A)
  endtask

  // Reset, then the scenarios in order
  initial
  begin
    {clk, bemf, sector, osc, thermal_flag, speed_pulse_internal, sync_flag} = 7'h00;
    {sys_rst, brake_n, rst_n} = 3'h7;
    {avs_read, avs_write, avs_address, avs_writedata} = 42'h0;
    avs_byteenable = 4'hF;
    miscompares = 0;
    cmp_count = 0;
    wt(3);
    sys_rst <= 1'b0;
    t_regs();
    t_word();
    t_diag();
    t_brake();
    t_rstpin();
    t_zc();
    t_osc();
    end_of_test();
  end
endmodule

bind mcsp_top mcsp_top_asserts chk (.clk(clk), .sys_rst(sys_rst), .pins(pins),
  .thermal_flag(thermal_flag), .avs_address(avs_address), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .data_out(data_out), .sink_on(sink_on), .sleep(sleep),
  .zero_cross_indicator(zero_cross_indicator));
